/* logic/lfs_pkg.sv */
package lfs_pkg;

    // register word indices; byte address is four times the index
    localparam logic [29:0] LFS_IDX_CFG      = 30'h0000_0405;
    localparam logic [29:0] LFS_IDX_STATUS   = 30'h0000_0406;
    localparam logic [29:0] LFS_IDX_CNT_LOC  = 30'h0000_0407;
    localparam logic [29:0] LFS_IDX_CNT_REM  = 30'h0000_0408;
    localparam logic [29:0] LFS_IDX_CNT_INS  = 30'h0000_0409;

    // configuration fields and reset value
    localparam int          LFS_CFG_GEN_BIT  = 0;
    localparam int          LFS_CFG_UNI_BIT  = 1;
    localparam logic [1:0]  LFS_CFG_RST      = 2'h0;

    // status register fields
    localparam int          LFS_ST_LOC_BIT   = 0;
    localparam int          LFS_ST_REM_BIT   = 1;
    localparam int          LFS_ST_FLT_LSB   = 2;

    // event counters
    localparam int          LFS_CNT_W        = 16;
    localparam int          LFS_NUM_CNT      = 3;
    localparam int          LFS_CNT_LOC      = 0;
    localparam int          LFS_CNT_REM      = 1;
    localparam int          LFS_CNT_INS      = 2;

    // fault tracking figures
    localparam int          LFS_COL_WINDOW   = 128;
    localparam int          LFS_SEQ_NEEDED   = 4;

    // column characters
    localparam logic [7:0]  LFS_CH_IDLE      = 8'h07;
    localparam logic [7:0]  LFS_CH_SEQ       = 8'h9C;
    localparam logic [3:0]  LFS_SEQ_CTL      = 4'h1;
    localparam logic [7:0]  LFS_CTL_ALL      = 8'hFF;

    // fault value; code equals the sequence type byte
    typedef enum logic [1:0] {
        LFS_OK     = 2'h0,
        LFS_LOCAL  = 2'h1,
        LFS_REMOTE = 2'h2
    } lfs_fault_t;

    // tracker states, one-hot
    typedef enum logic [2:0] {
        LFS_TS_INIT  = 3'b001,
        LFS_TS_COUNT = 3'b010,
        LFS_TS_FAULT = 3'b100
    } lfs_trk_state_t;

    // one 64-bit column with its control lane
    typedef struct packed {
        logic [7:0]  ctl;
        logic [63:0] dat;
    } lfs_col_t;

    localparam lfs_col_t LFS_COL_IDLE = '{ctl: 8'hFF, dat: 64'h0707_0707_0707_0707};

    // build a sequence column carrying the given fault value
    function automatic lfs_col_t lfs_make_seq(input lfs_fault_t f);
        lfs_col_t c;
        c.ctl = {4'h0, LFS_SEQ_CTL};
        c.dat = {32'h0000_0000, 6'h00, f, 16'h0000, LFS_CH_SEQ};
        return c;
    endfunction

    // fault value carried by a column, OK when none
    function automatic lfs_fault_t lfs_decode_seq(input lfs_col_t c);
        lfs_fault_t f;
        f = LFS_OK;
        if (c.ctl[3:0] == LFS_SEQ_CTL && c.dat[7:0] == LFS_CH_SEQ
            && c.dat[23:8] == 16'h0000 && c.dat[31:26] == 6'h00) begin
            if (c.dat[25:24] == LFS_LOCAL || c.dat[25:24] == LFS_REMOTE) begin
                f = lfs_fault_t'(c.dat[25:24]);
            end
        end
        return f;
    endfunction

    // column made only of idle characters
    function automatic logic lfs_is_idle(input lfs_col_t c);
        return c.ctl == LFS_CTL_ALL && c.dat == LFS_COL_IDLE.dat;
    endfunction

endpackage

/* logic/lfs_fault_tracker.sv */
`timescale 1ns/100ps
`default_nettype none

module lfs_fault_tracker #(
    parameter int COL_WINDOW = lfs_pkg::LFS_COL_WINDOW,
    parameter int SEQ_NEEDED = lfs_pkg::LFS_SEQ_NEEDED
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               ce_i,
    input  wire logic               col_vld_i,
    input  wire lfs_pkg::lfs_fault_t seq_i,
    output var  lfs_pkg::lfs_fault_t link_fault_o
);
    import lfs_pkg::*;

    localparam int             CW       = $clog2(COL_WINDOW);
    localparam logic [CW-1:0]  COL_LAST = CW'(COL_WINDOW - 1);
    localparam logic [3:0]     SEQ_LAST = 4'(SEQ_NEEDED);

    lfs_trk_state_t state, next_state;
    lfs_fault_t     last_seq, next_last_seq;
    lfs_fault_t     next_link_fault;
    logic [CW-1:0]  col_cnt, next_col_cnt;
    logic [3:0]     seq_cnt, next_seq_cnt;

    // next state of the link fault tracker
    always_comb begin
        next_state      = state;
        next_last_seq   = last_seq;
        next_link_fault = link_fault_o;
        next_col_cnt    = col_cnt;
        next_seq_cnt    = seq_cnt;
        if (col_vld_i) begin
            if (seq_i != LFS_OK) begin
                next_col_cnt = '0;
                case (state)
                    LFS_TS_INIT: begin
                        next_last_seq = seq_i;
                        next_seq_cnt  = 4'h1;
                        next_state    = LFS_TS_COUNT;
                    end
                    LFS_TS_COUNT, LFS_TS_FAULT: begin
                        if (seq_i != last_seq) begin
                            // new fault type restarts the count
                            next_last_seq = seq_i;
                            next_seq_cnt  = 4'h1;
                            next_state    = LFS_TS_COUNT;
                        end else if (state == LFS_TS_COUNT) begin
                            next_seq_cnt = seq_cnt + 4'h1;
                            if (seq_cnt + 4'h1 >= SEQ_LAST) begin
                                next_state      = LFS_TS_FAULT;
                                next_link_fault = last_seq;
                            end
                        end
                    end
                    default: begin
                        next_state = LFS_TS_INIT;
                    end
                endcase
            end else if (state != LFS_TS_INIT) begin
                if (col_cnt == COL_LAST) begin
                    // quiet window elapsed: back to OK
                    next_state      = LFS_TS_INIT;
                    next_link_fault = LFS_OK;
                    next_last_seq   = LFS_OK;
                    next_seq_cnt    = 4'h0;
                    next_col_cnt    = '0;
                end else begin
                    next_col_cnt = col_cnt + CW'(1);
                end
            end
        end
    end

    // tracker registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state        <= LFS_TS_INIT;
            last_seq     <= LFS_OK;
            link_fault_o <= LFS_OK;
            col_cnt      <= '0;
            seq_cnt      <= 4'h0;
        end else if (ce_i) begin
            state        <= next_state;
            last_seq     <= next_last_seq;
            link_fault_o <= next_link_fault;
            col_cnt      <= next_col_cnt;
            seq_cnt      <= next_seq_cnt;
        end
    end

endmodule // lfs_fault_tracker

`default_nettype wire

/* logic/lfs_rs.sv */
// Local design decision: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none

// Function
// - transmit fault signaling is off after reset; enabled by config bit 0
// - mode 01: send remote fault sequences while a local fault is seen
// - mode 01: send idle columns instead of frames while remote fault seen
// - mode 11: fault sequences go only into interpacket gaps, frames intact
// - receive side raises remote or local fault flag on matching sequences
// - flag clears after more than 127 columns without fault sequences
// - only each received column's low 4 control bits and low 32 data bits are inspected
// - fault value taken after four same sequences, under 128 columns apart
// - fault state returns to OK after 128 columns without fault sequences
// - fault flags follow receive detection whatever the configuration holds
// - fault flags are registered on clk_i, the single module clock
// - one-way mode output follows config bit 1
// - fault emission enable output follows config bit 0
// - both enable outputs are registered on clk_i, the single module clock
module lfs_rs #(
    parameter int COL_WINDOW = lfs_pkg::LFS_COL_WINDOW,
    parameter int SEQ_NEEDED = lfs_pkg::LFS_SEQ_NEEDED
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    // classic wishbone slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [31:0]      wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    // receive columns from the pcs side
    input  wire logic             rx_vld_i,
    input  wire lfs_pkg::lfs_col_t rx_col_i,
    // transmit columns from the mac, and towards the pcs
    input  wire logic             tx_vld_i,
    input  wire lfs_pkg::lfs_col_t tx_col_i,
    output logic                  tx_vld_o,
    output var  lfs_pkg::lfs_col_t tx_col_o,
    // fault status and enables
    output logic                  local_fault_status_o,
    output logic                  remote_fault_status_o,
    output logic                  unidir_en_o,
    output logic                  fault_gen_en_o
);
    import lfs_pkg::*;

    // bus decode helper, used for every register
    function automatic logic reg_hit(input logic [31:0] adr, input logic [29:0] idx);
        return adr[31:2] == idx;
    endfunction

    logic [1:0]            cfg;
    logic                  bus_req;
    logic                  bus_wr;
    logic [31:0]           next_rdata;
    lfs_fault_t            rx_seq;
    lfs_fault_t            link_fault;
    lfs_fault_t            link_fault_d;
    lfs_col_t              next_tx_col;
    logic                  next_inserted;
    logic [LFS_CNT_W-1:0]  cnt      [LFS_NUM_CNT];
    logic [LFS_NUM_CNT-1:0] cnt_inc;
    logic [LFS_NUM_CNT-1:0] cnt_clr;

    // a request is taken on the edge where it stands and ack is low
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr  = bus_req && wb_we_i;

    // ack for one cycle, one edge after the request is seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= bus_req;
        end
    end

    // configuration register, low byte lane holds both fields
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg <= LFS_CFG_RST;
        end else if (ce_i) begin
            if (bus_wr && wb_sel_i[0] && reg_hit(wb_adr_i, LFS_IDX_CFG)) begin
                cfg <= wb_dat_i[1:0];
            end
        end
    end

    // read data selection; unmapped words read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (reg_hit(wb_adr_i, LFS_IDX_CFG)) begin
            next_rdata[1:0] = cfg;
        end else if (reg_hit(wb_adr_i, LFS_IDX_STATUS)) begin
            next_rdata[LFS_ST_LOC_BIT]              = local_fault_status_o;
            next_rdata[LFS_ST_REM_BIT]              = remote_fault_status_o;
            next_rdata[LFS_ST_FLT_LSB+1:LFS_ST_FLT_LSB] = link_fault;
        end else if (reg_hit(wb_adr_i, LFS_IDX_CNT_LOC)) begin
            next_rdata[LFS_CNT_W-1:0] = cnt[LFS_CNT_LOC];
        end else if (reg_hit(wb_adr_i, LFS_IDX_CNT_REM)) begin
            next_rdata[LFS_CNT_W-1:0] = cnt[LFS_CNT_REM];
        end else if (reg_hit(wb_adr_i, LFS_IDX_CNT_INS)) begin
            next_rdata[LFS_CNT_W-1:0] = cnt[LFS_CNT_INS];
        end
    end

    // read data captured with the ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= next_rdata;
            end
        end
    end

    // receive column inspection, control and data lanes together
    assign rx_seq = rx_vld_i ? lfs_decode_seq(rx_col_i) : LFS_OK;

    // link fault state machine over received columns
    lfs_fault_tracker #(
        .COL_WINDOW (COL_WINDOW),
        .SEQ_NEEDED (SEQ_NEEDED)
    ) u_tracker (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .ce_i         (ce_i),
        .col_vld_i    (rx_vld_i),
        .seq_i        (rx_seq),
        .link_fault_o (link_fault)
    );

    // fault flags, independent of the configuration
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            local_fault_status_o  <= 1'b0;
            remote_fault_status_o <= 1'b0;
        end else if (ce_i) begin
            local_fault_status_o  <= link_fault == LFS_LOCAL;
            remote_fault_status_o <= link_fault == LFS_REMOTE;
        end
    end

    // enable outputs mirror the configuration fields
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unidir_en_o    <= 1'b0;
            fault_gen_en_o <= 1'b0;
        end else if (ce_i) begin
            unidir_en_o    <= cfg[LFS_CFG_UNI_BIT];
            fault_gen_en_o <= cfg[LFS_CFG_GEN_BIT];
        end
    end

    // transmit column choice from mode and fault state
    always_comb begin
        next_tx_col   = tx_col_i;
        next_inserted = 1'b0;
        if (cfg[LFS_CFG_GEN_BIT] && tx_vld_i) begin
            if (!cfg[LFS_CFG_UNI_BIT]) begin
                if (link_fault == LFS_LOCAL) begin
                    next_tx_col   = lfs_make_seq(LFS_REMOTE);
                    next_inserted = 1'b1;
                end else if (link_fault == LFS_REMOTE) begin
                    next_tx_col = LFS_COL_IDLE;
                end
            end else if (link_fault == LFS_LOCAL && lfs_is_idle(tx_col_i)) begin
                // only idle columns are replaced, frames go through
                next_tx_col   = lfs_make_seq(LFS_REMOTE);
                next_inserted = 1'b1;
            end
        end
    end

    // transmit output register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_vld_o <= 1'b0;
            tx_col_o <= LFS_COL_IDLE;
        end else if (ce_i) begin
            tx_vld_o <= tx_vld_i;
            tx_col_o <= next_tx_col;
        end
    end

    // previous fault value, for entry events
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link_fault_d <= LFS_OK;
        end else if (ce_i) begin
            link_fault_d <= link_fault;
        end
    end

    // counter events and clears by a write to the counter word
    assign cnt_inc[LFS_CNT_LOC] = link_fault == LFS_LOCAL && link_fault_d != LFS_LOCAL;
    assign cnt_inc[LFS_CNT_REM] = link_fault == LFS_REMOTE && link_fault_d != LFS_REMOTE;
    assign cnt_inc[LFS_CNT_INS] = next_inserted;
    assign cnt_clr[LFS_CNT_LOC] = bus_wr && reg_hit(wb_adr_i, LFS_IDX_CNT_LOC);
    assign cnt_clr[LFS_CNT_REM] = bus_wr && reg_hit(wb_adr_i, LFS_IDX_CNT_REM);
    assign cnt_clr[LFS_CNT_INS] = bus_wr && reg_hit(wb_adr_i, LFS_IDX_CNT_INS);

    // saturating event counters; an event in the clearing cycle counts
    generate
        for (genvar i = 0; i < LFS_NUM_CNT; i++) begin : g_cnt
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    cnt[i] <= '0;
                end else if (ce_i) begin
                    if (cnt_clr[i]) begin
                        cnt[i] <= LFS_CNT_W'(cnt_inc[i]);
                    end else if (cnt_inc[i] && cnt[i] != '1) begin
                        cnt[i] <= cnt[i] + LFS_CNT_W'(1);
                    end
                end
            end
        end
    endgenerate

endmodule // lfs_rs

`default_nettype wire

/* testbench/lfs_rs_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module lfs_rs_chk #(
    parameter int COL_WINDOW = 128
) (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              ce_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [31:0]       wb_adr_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic              rx_vld_i,
    input wire lfs_pkg::lfs_col_t rx_col_i,
    input wire logic              tx_vld_i,
    input wire lfs_pkg::lfs_col_t tx_col_i,
    input wire logic              tx_vld_o,
    input wire lfs_pkg::lfs_col_t tx_col_o,
    input wire logic              local_fault_status_o,
    input wire logic              remote_fault_status_o,
    input wire logic              unidir_en_o,
    input wire logic              fault_gen_en_o
);
    import lfs_pkg::*;
    localparam lfs_col_t SEQ_REM = {8'h01, 64'h0000_0000_0200_009C};
    logic [15:0] quiet;
    logic        seq;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // sequence column seen on receive
    assign seq = rx_col_i.ctl[3:0] == 4'h1 && rx_col_i.dat[7:0] == 8'h9C;
    // valid columns since the last sequence, saturating
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            quiet <= '0;
        end else if (rx_vld_i && ce_i) begin
            quiet <= seq ? 16'h0 : (quiet == 16'hFFFF ? quiet : quiet + 16'h1);
        end
    end
    sequence s_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_wr_cfg;
        s_taken ##0 wb_we_i && wb_adr_i == 32'h0000_1014 && wb_sel_i[0];
    endsequence
    sequence s_off;
        !fault_gen_en_o ##1 !fault_gen_en_o;
    endsequence
    property p_cfg;
        s_wr_cfg |=> ##1 fault_gen_en_o == $past(wb_dat_i[0], 2)
            && unidir_en_o == $past(wb_dat_i[1], 2);
    endproperty
    property p_ack;
        s_taken |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    property p_rst;
        disable iff (1'b0) rst_i |=> !fault_gen_en_o && !unidir_en_o
            && !local_fault_status_o && !remote_fault_status_o;
    endproperty
    property p_pass;
        s_off |-> tx_vld_o == $past(tx_vld_i) && tx_col_o == $past(tx_col_i);
    endproperty
    property p_bi_loc;
        (fault_gen_en_o && !unidir_en_o && local_fault_status_o)[*3]
            ##0 $past(tx_vld_i) |-> tx_col_o == SEQ_REM;
    endproperty
    property p_bi_rem;
        (fault_gen_en_o && !unidir_en_o && remote_fault_status_o)[*3]
            ##0 $past(tx_vld_i) |-> tx_col_o == LFS_COL_IDLE;
    endproperty
    property p_uni_loc;
        (fault_gen_en_o && unidir_en_o && local_fault_status_o)[*3]
            ##0 $past(tx_col_i) != LFS_COL_IDLE |-> tx_col_o == $past(tx_col_i);
    endproperty
    property p_clear;
        quiet == COL_WINDOW |-> ##2 !local_fault_status_o && !remote_fault_status_o;
    endproperty
    a_cfg: assert property (p_cfg) else $error("enable outputs miss config");
    a_ack: assert property (p_ack) else $error("ack not one cycle");
    a_rst: assert property (p_rst) else $error("outputs active after reset");
    a_pass: assert property (p_pass) else $error("tx altered while off");
    a_bi_loc: assert property (p_bi_loc) else $error("no remote seq inserted");
    a_bi_rem: assert property (p_bi_rem) else $error("no idle on remote");
    a_uni_loc: assert property (p_uni_loc) else $error("frame altered one-way");
    a_clear: assert property (p_clear) else $error("flag not cleared");
endmodule // lfs_rs_chk

bind lfs_rs lfs_rs_chk #(.COL_WINDOW(COL_WINDOW)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_vld_i(rx_vld_i), .rx_col_i(rx_col_i),
    .tx_vld_i(tx_vld_i), .tx_col_i(tx_col_i), .tx_vld_o(tx_vld_o), .tx_col_o(tx_col_o),
    .local_fault_status_o(local_fault_status_o), .unidir_en_o(unidir_en_o),
    .remote_fault_status_o(remote_fault_status_o), .fault_gen_en_o(fault_gen_en_o));
`default_nettype wire

/* testbench/lfs_pcs_model.sv */
`timescale 1ns/100ps
`default_nettype none
module lfs_pcs_model (
    input  wire logic             clk_i,
    input  wire logic [1:0]       kind_i,
    output logic                  rx_vld_o,
    output var lfs_pkg::lfs_col_t rx_col_o
);
    import lfs_pkg::*;
    logic [71:0] junk = 72'h5A_A5C3_3C96_6955_AA33;
    // toggles so an invalid column never repeats on the next cycle
    always @(posedge clk_i) begin
        junk <= ~junk;
    end
    // column source: idle, local seq, remote seq, or no column
    always_comb begin
        rx_vld_o = kind_i != 2'h3;
        case (kind_i)
            2'h0: rx_col_o = {8'hFF, 64'h0707_0707_0707_0707};
            2'h1: rx_col_o = {8'h01, 64'h0000_0000_0100_009C};
            2'h2: rx_col_o = {8'h01, 64'h0000_0000_0200_009C};
            default: rx_col_o = junk;
        endcase
    end
endmodule // lfs_pcs_model
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import lfs_pkg::*;
    localparam int W = 16;
    localparam lfs_col_t REM = {8'h01, 64'h0000_0000_0200_009C};
    localparam lfs_col_t FRM = {8'h00, 64'h1122_3344_5566_7788};
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, tx_vld = 1'b0;
    logic [31:0] adr = '0, wdat = '0, rdat, q;
    logic [3:0]  sel = '0;
    logic        ack, rx_vld, tv_o, loc, rem, uni, gen;
    logic [1:0]  kind = 2'h3;
    lfs_col_t    rx_col, tc_o, tx_col = '0;
    int          err_total = 0, checked = 0, cycles = 0;

    always #50 clk_i = ~clk_i;

    lfs_pcs_model u_pcs (.clk_i(clk_i), .kind_i(kind), .rx_vld_o(rx_vld), .rx_col_o(rx_col));
    lfs_rs #(.COL_WINDOW(W), .SEQ_NEEDED(4)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .rx_vld_i(rx_vld), .rx_col_i(rx_col), .tx_vld_i(tx_vld),
        .tx_col_i(tx_col), .tx_vld_o(tv_o), .tx_col_o(tc_o), .local_fault_status_o(loc),
        .remote_fault_status_o(rem), .unidir_en_o(uni), .fault_gen_en_o(gen));

    task automatic results();
        if (err_total == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // cut a hang short
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 20000) begin
            err_total++;
            $display("unexpected %0t timeout", $time);
            results();
        end
    end
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one classic wishbone cycle, read data left in q
    task automatic wb(input logic w, input logic [31:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        chk(ack, 1'b1);
    endtask
    task automatic send(input logic [1:0] k, input int n);
        repeat (n) begin
            @(posedge clk_i);
            kind <= k;
        end
        @(posedge clk_i);
        kind <= 2'h3;
    endtask
    task automatic txc(input lfs_col_t c, input lfs_col_t e);
        @(posedge clk_i);
        tx_col <= c;
        tx_vld <= 1'b1;
        @(posedge clk_i);
        @(negedge clk_i);
        chk(tc_o, e);
        chk(tv_o, 1'b1);
    endtask
    task automatic st(input logic l, input logic r);
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        chk({loc, rem}, {l, r});
    endtask
    // reset values, unmapped read, config write with and without lane 0
    task automatic t_regs();
        st(1'b0, 1'b0);
        chk({gen, uni}, 2'h0);
        wb(1'b0, 32'h0000_1014, 4'hF, '0);
        chk(q, 32'h0);
        wb(1'b0, 32'h0000_2000, 4'hF, '0);
        chk(q, 32'h0);
        txc(FRM, FRM);
        wb(1'b1, 32'h0000_1014, 4'h0, 32'h3);
        wb(1'b0, 32'h0000_1014, 4'hF, '0);
        chk(q, 32'h0);
        wb(1'b1, 32'h0000_1014, 4'hF, 32'h2);
        st(1'b0, 1'b0);
        chk({gen, uni}, 2'h1);
        wb(1'b1, 32'h0000_1014, 4'hF, 32'h0);
    endtask
    // local fault forms at the fourth sequence, widest legal gap
    task automatic t_local();
        send(2'h1, 1);
        send(2'h0, W - 1);
        send(2'h1, 2);
        st(1'b0, 1'b0);
        send(2'h1, 1);
        st(1'b1, 1'b0);
        wb(1'b0, 32'h0000_1018, 4'hF, '0);
        chk(q, 32'h5);
        wb(1'b0, 32'h0000_101C, 4'hF, '0);
        chk(q, 32'h1);
        wb(1'b1, 32'h0000_1014, 4'hF, 32'h1);
        txc(FRM, REM);
        wb(1'b1, 32'h0000_1014, 4'hF, 32'h3);
        txc(FRM, FRM);
        chk({gen, uni}, 2'h3);
        txc(LFS_COL_IDLE, REM);
    endtask
    // flag holds through W-1 quiet columns, drops after W
    task automatic t_clear();
        send(2'h0, W - 1);
        st(1'b1, 1'b0);
        send(2'h0, 1);
        st(1'b0, 1'b0);
    endtask
    // a local sequence restarts the remote count
    task automatic t_remote();
        wb(1'b1, 32'h0000_1014, 4'hF, 32'h1);
        send(2'h2, 3);
        send(2'h1, 1);
        send(2'h2, 3);
        st(1'b0, 1'b0);
        send(2'h2, 1);
        st(1'b0, 1'b1);
        txc(FRM, LFS_COL_IDLE);
        wb(1'b1, 32'h0000_1014, 4'hF, 32'h0);
        repeat (2) @(posedge clk_i);
        txc(FRM, FRM);
        wb(1'b1, 32'h0000_1014, 4'hF, 32'h3);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        st(1'b0, 1'b0);
        chk({gen, uni}, 2'h0);
        wb(1'b0, 32'h0000_1014, 4'hF, '0);
        chk(q, 32'h0);
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_local();
        t_clear();
        t_remote();
        results();
    end
endmodule // tb_top
`default_nettype wire
